//--- ais_params.svh
// constants for the accumulator instruction slice: register offsets, field positions, reset values
// assumes inclusion by bare name from the core and the testbench
// How it works
// RULE1 - immediate minus working register, result to working
// RULE2 - table address is pointer bits 2:0 over working
// RULE3 - word upper six bits go to table data high
// RULE4 - program words hold bits 13:8 above low byte
// RULE5 - working register copied to timer0 mode, flags kept
// RULE6 - timer0 mode copied to working, flags kept
// RULE7 - xor with file register 0..63, zero flag only
// RULE8 - target bit 0 to working, 1 to file
// RULE9 - xor with immediate into working, zero flag only
// RULE10 - carry and half-borrow set when no borrow
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH
// wishbone word offsets (byte addresses)
`define AIS_ADDR_CMD 8'h00
`define AIS_ADDR_WORK 8'h04
`define AIS_ADDR_STATUS 8'h08
`define AIS_ADDR_TMODE 8'h0c
`define AIS_ADDR_TPH 8'h10
`define AIS_ADDR_TDH 8'h14
`define AIS_ADDR_FILE 8'h18
`define AIS_ADDR_ROM_ADDR 8'h1c
`define AIS_ADDR_ROM_DATA 8'h20
// command register fields
`define AIS_CMD_OP_LSB 0
`define AIS_CMD_OP_MSB 2
`define AIS_CMD_IMM_LSB 8
`define AIS_CMD_IMM_MSB 15
`define AIS_CMD_FADDR_LSB 16
`define AIS_CMD_FADDR_MSB 21
`define AIS_CMD_DEST_BIT 24
// status bit positions
`define AIS_ST_CARRY 0
`define AIS_ST_HALF 1
`define AIS_ST_ZERO 2
`define AIS_ST_BUSY 3
// reset values
`define AIS_RST_BYTE 8'h00
`define AIS_RST_TMODE 8'h00
// pointer bits that extend the table address, and program word field bounds
`define AIS_TPH_USED_MSB 2
`define AIS_ROM_HI_MSB 13
`define AIS_ROM_LO_MSB 7
`endif

//--- ais_pkg.sv
// types shared by the instruction slice modules
// assumes ais_params.svh holds the numeric constants
package ais_pkg;
	// opcodes of the slice, written into the command register
	typedef enum logic [2:0]
	{
		AIS_OP_NOP = 3'h0,
		AIS_OP_SUB_IMM = 3'h1,
		AIS_OP_TABLE_READ = 3'h2,
		AIS_OP_WORK_TO_TMODE = 3'h3,
		AIS_OP_TMODE_TO_WORK = 3'h4,
		AIS_OP_XOR_FILE = 3'h5,
		AIS_OP_XOR_IMM = 3'h6
	} ais_op_type;
	// execution sequencer states, gray along wait-exec-idle
	typedef enum logic [1:0]
	{
		AIS_ST_IDLE = 2'b00,
		AIS_ST_EXEC = 2'b01,
		AIS_ST_WAIT = 2'b11
	} ais_state_type;
endpackage

//--- ais_alu.sv
// combinational arithmetic for the slice: subtract and exclusive-or with flags
// assumes operands are stable while the caller samples the outputs
`timescale 1ns/10ps
module ais_alu
(
	input wire logic [7:0] i_lhs,
	input wire logic [7:0] i_rhs,
	input wire logic i_sub,
	output logic [7:0] o_result,
	output logic o_carry,
	output logic o_half,
	output logic o_zero
);
	import ais_pkg::*;
	// nine-bit difference: bit 8 high means no borrow
	wire [8:0] diff = {1'b1, i_lhs} - {1'b0, i_rhs};
	wire [4:0] nib = {1'b1, i_lhs[3:0]} - {1'b0, i_rhs[3:0]};
	// selection of the result by operation
	assign o_result = i_sub ? diff[7:0] : (i_lhs ^ i_rhs); // RULE1 RULE7 RULE9
	assign o_carry = diff[8]; // RULE10
	assign o_half = nib[4]; // RULE10
	assign o_zero = (o_result == 8'h00); // RULE10
endmodule // ais_alu

//--- ais_file_ram.sv
// file register memory of 64 bytes, one write port and one async read port
// assumes the caller holds address stable for a combinational read
`timescale 1ns/10ps
module ais_file_ram
#(
	parameter int DEPTH = 64
)
(
	input wire logic I_CLOCK,
	input wire logic i_we,
	input wire logic [5:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [5:0] i_raddr,
	output logic [7:0] o_rdata
);
	import ais_pkg::*;
	// the address width serves exactly 64 entries, so any other depth is refused at elaboration
	if (DEPTH != 64)
	begin : g_depth_check
		$error("ais_file_ram depth must be 64");
	end
	logic [7:0] mem_ff [0:DEPTH-1]; // file register storage, no reset by design
	// single write port
	always_ff @(posedge I_CLOCK)
	begin
		if (i_we)
			mem_ff[i_waddr] <= i_wdata;
	end
	assign o_rdata = mem_ff[i_raddr];
endmodule // ais_file_ram

//--- ais_core.sv
// instruction slice of an 8-bit accumulator core, driven from a classic wishbone slave
// assumes an external program memory answering in a fixed one cycle after O_ROM_ADDR changes
`timescale 1ns/10ps
`include "ais_params.svh"
module ais_core
(
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	output logic [10:0] O_ROM_ADDR,
	input wire logic [13:0] I_ROM_DATA,
	output logic [7:0] O_TIMER0_MODE
);
	import ais_pkg::*;

	// architectural state
	logic [7:0] working_ff; // working register
	logic [7:0] tmode_ff; // timer0 mode register
	logic [7:0] tph_ff; // table pointer high
	logic [5:0] tdh_ff; // table data high
	logic carry_ff, half_ff, zero_ff; // status flags
	logic [10:0] rom_addr_ff; // table address to program memory
	logic [31:0] rd_ff; // bus read data
	logic ack_ff; // bus acknowledge
	ais_state_type state_ff, nxt_state; // sequencer
	ais_op_type op_ff; // latched opcode
	logic [7:0] imm_ff; // latched immediate
	logic [5:0] faddr_ff; // latched file address
	logic dest_ff; // latched result target bit
	logic [5:0] file_ptr_ff; // file window pointer for bus access

	// bus decode: one request, one ack, then ack drops
	wire req = I_WB_CYC & I_WB_STB & ~ack_ff;
	wire wr = req & I_WB_WE & I_WB_SEL[0];
	wire wr_cmd = wr & (I_WB_ADR == `AIS_ADDR_CMD) & (state_ff == AIS_ST_IDLE);
	wire wr_work = wr & (I_WB_ADR == `AIS_ADDR_WORK);
	wire wr_tmode = wr & (I_WB_ADR == `AIS_ADDR_TMODE);
	wire wr_tph = wr & (I_WB_ADR == `AIS_ADDR_TPH);
	wire wr_file = wr & (I_WB_ADR == `AIS_ADDR_FILE);
	wire wr_fptr = wr & (I_WB_ADR == `AIS_ADDR_ROM_ADDR);
	wire wr_status = wr & (I_WB_ADR == `AIS_ADDR_STATUS);

	// command fields from the write data
	wire [2:0] cmd_op = I_WB_DAT[`AIS_CMD_OP_MSB:`AIS_CMD_OP_LSB];
	wire [7:0] cmd_imm = I_WB_DAT[`AIS_CMD_IMM_MSB:`AIS_CMD_IMM_LSB];
	wire [5:0] cmd_faddr = I_WB_DAT[`AIS_CMD_FADDR_MSB:`AIS_CMD_FADDR_LSB];

	// file register memory
	wire [7:0] file_rdata;
	wire exec = (state_ff == AIS_ST_EXEC);
	wire [5:0] ram_raddr = exec ? faddr_ff : file_ptr_ff;
	wire file_wb = exec & (op_ff == AIS_OP_XOR_FILE) & dest_ff; // RULE8
	wire ram_we = file_wb | wr_file;
	wire [5:0] ram_waddr = file_wb ? faddr_ff : file_ptr_ff;
	wire [7:0] alu_res;
	wire [7:0] ram_wdata = file_wb ? alu_res : I_WB_DAT[7:0];
	ais_file_ram #(.DEPTH(64)) u_file
	(
		.I_CLOCK(I_CLOCK),
		.i_we(ram_we),
		.i_waddr(ram_waddr),
		.i_wdata(ram_wdata),
		.i_raddr(ram_raddr),
		.o_rdata(file_rdata)
	);

	// alu operands: subtract takes immediate minus working
	wire is_sub = (op_ff == AIS_OP_SUB_IMM);
	wire [7:0] alu_rhs = (op_ff == AIS_OP_XOR_FILE) ? file_rdata : working_ff;
	wire [7:0] alu_lhs = is_sub ? imm_ff : ((op_ff == AIS_OP_XOR_IMM) ? imm_ff : working_ff);
	wire alu_c, alu_h, alu_z;
	ais_alu u_alu
	(
		.i_lhs(alu_lhs),
		.i_rhs(alu_rhs),
		.i_sub(is_sub),
		.o_result(alu_res),
		.o_carry(alu_c),
		.o_half(alu_h),
		.o_zero(alu_z)
	);

	// read mux, unmapped addresses read as zero
	wire [31:0] status_word = {28'h0000000, (state_ff != AIS_ST_IDLE), zero_ff, half_ff, carry_ff};
	wire [31:0] rd_mux =
		(I_WB_ADR == `AIS_ADDR_CMD) ? {24'h000000, imm_ff} :
		(I_WB_ADR == `AIS_ADDR_WORK) ? {24'h000000, working_ff} :
		(I_WB_ADR == `AIS_ADDR_STATUS) ? status_word :
		(I_WB_ADR == `AIS_ADDR_TMODE) ? {24'h000000, tmode_ff} :
		(I_WB_ADR == `AIS_ADDR_TPH) ? {24'h000000, tph_ff} :
		(I_WB_ADR == `AIS_ADDR_TDH) ? {26'h0, tdh_ff} :
		(I_WB_ADR == `AIS_ADDR_FILE) ? {24'h000000, file_rdata} :
		(I_WB_ADR == `AIS_ADDR_ROM_ADDR) ? {26'h0, file_ptr_ff} :
		(I_WB_ADR == `AIS_ADDR_ROM_DATA) ? {18'h0, I_ROM_DATA} :
		32'h00000000;

	// table address: pointer bits 2:0 above working register
	wire [10:0] tab_addr = {tph_ff[`AIS_TPH_USED_MSB:0], working_ff}; // RULE2

	// sequencer: idle, then a wait for the table word on a table read, then one execute cycle
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			AIS_ST_IDLE: if (wr_cmd) nxt_state = (cmd_op == AIS_OP_TABLE_READ) ? AIS_ST_WAIT : AIS_ST_EXEC;
			AIS_ST_WAIT: nxt_state = AIS_ST_EXEC; // program memory has one cycle latency
			AIS_ST_EXEC: nxt_state = AIS_ST_IDLE;
			default: nxt_state = AIS_ST_IDLE;
		endcase
	end

	// bus handshake and sequencer state
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			ack_ff <= 1'b0;
			rd_ff <= 32'h00000000;
			state_ff <= AIS_ST_IDLE;
		end
		else
		begin
			ack_ff <= req;
			// read data only moves on a read, so it stands across later writes
			rd_ff <= (req & ~I_WB_WE) ? rd_mux : rd_ff;
			state_ff <= nxt_state;
		end
	end

	// command latch
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			op_ff <= AIS_OP_NOP;
			imm_ff <= `AIS_RST_BYTE;
			faddr_ff <= 6'h00;
			dest_ff <= 1'b0;
		end
		else if (wr_cmd)
		begin
			op_ff <= ais_op_type'(cmd_op);
			imm_ff <= cmd_imm;
			faddr_ff <= cmd_faddr;
			dest_ff <= I_WB_DAT[`AIS_CMD_DEST_BIT];
		end
	end

	// working register: bus writes lose to execution in the same cycle
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
			working_ff <= `AIS_RST_BYTE;
		else if (exec && (is_sub || op_ff == AIS_OP_XOR_IMM)) // RULE1 RULE9
			working_ff <= alu_res;
		else if (exec && op_ff == AIS_OP_XOR_FILE && !dest_ff) // RULE8
			working_ff <= alu_res;
		else if (exec && op_ff == AIS_OP_TMODE_TO_WORK) // RULE6
			working_ff <= tmode_ff;
		else if (exec && op_ff == AIS_OP_TABLE_READ) // RULE2
			working_ff <= I_ROM_DATA[`AIS_ROM_LO_MSB:0];
		else if (wr_work)
			working_ff <= I_WB_DAT[7:0];
	end

	// timer0 mode register, pointer and table data high
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			tmode_ff <= `AIS_RST_TMODE;
			tph_ff <= `AIS_RST_BYTE;
			tdh_ff <= 6'h00;
			file_ptr_ff <= 6'h00;
			rom_addr_ff <= 11'h000;
		end
		else
		begin
			if (exec && op_ff == AIS_OP_WORK_TO_TMODE) // RULE5
				tmode_ff <= working_ff;
			else if (wr_tmode)
				tmode_ff <= I_WB_DAT[7:0];
			if (wr_tph)
				tph_ff <= I_WB_DAT[7:0];
			if (exec && op_ff == AIS_OP_TABLE_READ) // RULE3 RULE4
				tdh_ff <= I_ROM_DATA[`AIS_ROM_HI_MSB:`AIS_ROM_LO_MSB+1];
			if (wr_fptr)
				file_ptr_ff <= I_WB_DAT[5:0];
			rom_addr_ff <= tab_addr;
		end
	end

	// status flags: only subtract and bus status writes touch carry and half-borrow
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			carry_ff <= 1'b0;
			half_ff <= 1'b0;
			zero_ff <= 1'b0;
		end
		else if (exec && is_sub) // RULE1 RULE10
		begin
			carry_ff <= alu_c;
			half_ff <= alu_h;
			zero_ff <= alu_z;
		end
		else if (exec && (op_ff == AIS_OP_XOR_FILE || op_ff == AIS_OP_XOR_IMM)) // RULE7 RULE9
			zero_ff <= alu_z;
		else if (wr_status)
		begin
			carry_ff <= I_WB_DAT[`AIS_ST_CARRY];
			half_ff <= I_WB_DAT[`AIS_ST_HALF];
			zero_ff <= I_WB_DAT[`AIS_ST_ZERO];
		end
	end

	// outputs straight from flip-flops
	assign O_WB_ACK = ack_ff;
	assign O_WB_DAT = rd_ff;
	assign O_ROM_ADDR = rom_addr_ff;
	assign O_TIMER0_MODE = tmode_ff;
endmodule // ais_core

//--- ais_core_properties.sv
// bus and output checks for the instruction slice
// assumes binding to ais_core, one clock, synchronous reset
`timescale 1ns/10ps
module ais_core_properties
(
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [31:0] O_WB_DAT,
	input wire logic O_WB_ACK,
	input wire logic [10:0] O_ROM_ADDR,
	input wire logic [13:0] I_ROM_DATA,
	input wire logic [7:0] O_TIMER0_MODE
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SRST);
	// request seen and not yet answered
	wire take = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	// only these writes may move the timer0 mode register
	wire tm_wr = take && I_WB_WE && I_WB_SEL[0] && (I_WB_ADR == 8'h0c || I_WB_ADR == 8'h00);
	sequence s_take; take; endsequence
	// long enough for a table read to finish and the address to follow
	sequence s_quiet; !I_WB_CYC [*4]; endsequence
	property p_ack_after; s_take |=> O_WB_ACK; endproperty
	a_ack_after: assert property (p_ack_after) else $error("ack missing");
	property p_ack_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause; O_WB_ACK |-> $past(take); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_rst; $fell(I_SRST) |-> !O_WB_ACK && O_ROM_ADDR == 0 && O_TIMER0_MODE == 0 && O_WB_DAT == 0; endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_tm_cause; $changed(O_TIMER0_MODE) |-> $past(tm_wr) || $past(tm_wr, 2); endproperty
	a_tm_cause: assert property (p_tm_cause) else $error("timer0 mode moved alone");
	property p_rd_cause; $changed(O_WB_DAT) |-> O_WB_ACK && !I_WB_WE; endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("read data moved alone");
	property p_unmap; O_WB_ACK && !I_WB_WE && I_WB_ADR > 8'h20 |-> O_WB_DAT == 0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_tm_rd; O_WB_ACK && !I_WB_WE && I_WB_ADR == 8'h0c |-> O_WB_DAT == {24'h0, O_TIMER0_MODE}; endproperty
	a_tm_rd: assert property (p_tm_rd) else $error("timer0 mode readback");
	property p_rom; s_quiet |-> $stable(O_ROM_ADDR); endproperty
	a_rom: assert property (p_rom) else $error("table address moved while idle");
endmodule // ais_core_properties
bind ais_core ais_core_properties ais_core_properties_inst (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
	.I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL),
	.I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_ROM_ADDR(O_ROM_ADDR),
	.I_ROM_DATA(I_ROM_DATA), .O_TIMER0_MODE(O_TIMER0_MODE));

//--- tb.sv
// self-checking bench for the instruction slice over wishbone
// assumes a combinational program memory pattern held here
`timescale 1ns/10ps
`include "ais_params.svh"
module tb;
	import ais_pkg::*;
	logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = 8'h00, tmode_o;
	logic [3:0] sel = 4'hf; // lane 0 always on: only lane 0 gates a register write
	logic [31:0] wdat = 32'h0, odat, q;
	logic [10:0] rom_addr;
	int fails = 0, tests_run = 0;
	int w, t, p, fa, f, st, op, imm, d, r, hd, i, a;
	// program word pattern, so every address gives a different word
	function automatic logic [13:0] rom(input logic [10:0] x);
		return {x[5:0], x[10:3]} ^ 14'h2b5;
	endfunction
	wire [13:0] rom_data = rom(rom_addr);
	ais_core ais_core_inst (.I_CLOCK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(odat), .O_WB_ACK(ack),
		.O_ROM_ADDR(rom_addr), .I_ROM_DATA(rom_data), .O_TIMER0_MODE(tmode_o));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task results();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// one classic cycle; request raised after an edge, held until the rising edge that samples ack high
	task wb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= ad;
		wdat <= dt;
		n = 0;
		@(posedge clk);
		while (ack !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				fails++;
				results();
			end
			@(posedge clk);
		end
		q = odat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	initial
	begin
		void'($urandom(53233));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wb(0, `AIS_ADDR_TMODE, 0);
		chk("tmode reset", 0, q);
		wb(0, 8'h40, 0);
		chk("unmapped", 0, q);
		hd = 0;
		// every opcode in turn, random operands
		for (i = 0; i < 36; i++)
		begin
			op = i % 7;
			w = $urandom % 256;
			p = $urandom % 256;
			t = $urandom % 256;
			fa = $urandom % 64;
			f = $urandom % 256;
			st = $urandom % 8;
			imm = $urandom % 256;
			d = $urandom % 2;
			wb(1, `AIS_ADDR_TPH, p);
			wb(1, `AIS_ADDR_WORK, w);
			wb(1, `AIS_ADDR_TMODE, t);
			wb(1, `AIS_ADDR_ROM_ADDR, fa);
			wb(1, `AIS_ADDR_FILE, f);
			wb(1, `AIS_ADDR_STATUS, st);
			wb(1, `AIS_ADDR_CMD, (d << 24) | (fa << 16) | (imm << 8) | op);
			q = 32'h8;
			a = 0;
			while (q[3] !== 1'b0 && a < 10)
			begin
				wb(0, `AIS_ADDR_STATUS, 0);
				a++;
			end
			// a command that never leaves busy is a hang
			if (q[3] !== 1'b0)
			begin
				fails++;
				results();
			end
			case (op)
				0: ;
				1:
				begin
					r = imm - w;
					st = ((r & 255) == 0) << 2 | ((imm & 15) >= (w & 15)) << 1 | (imm >= w);
					w = r & 255;
				end
				2:
				begin
					r = rom(((p & 7) << 8) | w);
					w = r & 255;
					hd = r >> 8;
				end
				3: t = w;
				4: w = t;
				default:
				begin
					r = w ^ (op == 5 ? f : imm);
					st = (st & 3) | ((r == 0) << 2);
					if (op == 5 && d == 1)
						f = r;
					else
						w = r;
				end
			endcase
			wb(0, `AIS_ADDR_WORK, 0);
			chk("work", w, q);
			wb(0, `AIS_ADDR_STATUS, 0);
			chk("status", st, q);
			wb(0, `AIS_ADDR_TMODE, 0);
			chk("tmode pin", t, tmode_o);
			chk("tmode read", t, q);
			wb(0, `AIS_ADDR_TDH, 0);
			chk("table high", hd, q);
			wb(0, `AIS_ADDR_FILE, 0);
			chk("file", f, q);
			chk("table address", ((p & 7) << 8) | w, rom_addr);
			repeat (5) @(posedge clk);
			$display("test %0d op %0d done", i, op);
		end
		results();
	end
endmodule // tb
